// File: verilog/adc_ctrl_consts.svh
// Offsets, field positions, reset values and timing counts of the trim and control logic
`ifndef ADC_CTRL_CONSTS_SVH
`define ADC_CTRL_CONSTS_SVH
// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_HZ 64'd200_000_000
`define TRIM_LOW_HOLD_CYCLES 16'h0010
`define TRIM_HIGH_HOLD_CYCLES 16'h0010
`define TRIM_RUN_CYCLES 32'h0000_0400
`define PU_WAIT_SHORT_CYCLES 32'h0000_1000
`define PU_WAIT_LONG_CYCLES 32'h0001_0000
`define POST_POWER_TRIM_S 64'd20
`define PIPE_DEPTH 14
`define PIPE_PRIMARY 12
`define PIPE_DELAYED 13
// ----------------------------------------
// Device registers
// ----------------------------------------
`define DEV_TRIM_REG 4'h0
`define DEV_CONFIG_REG 4'h1
`define DEV_REG_RESET 16'h0000
`define TRIM_START_BIT 15
`define CFG_SPAN_BIT 0
`define CFG_SWING_BIT 1
`define CFG_EDGE_BIT 2
`define CFG_DELAY_BIT 3
// ----------------------------------------
// Controller registers
// ----------------------------------------
`define HOST_CTRL 8'h00
`define HOST_STATUS 8'h04
`define HOST_CAPTURE 8'h08
`define HOST_DEVREG 8'h0c
`define HOST_CTRL_RESET 32'h0000_0008
`define CTRL_TRIM_BIT 0
`define CTRL_PD_BIT 1
`define CTRL_SLEEP_BIT 2
`define CTRL_SPAN_BIT 3
`define CTRL_SWING_BIT 4
`define CTRL_EDGE_BIT 5
`define CTRL_DELAY_BIT 6
`define CTRL_EXT_BIT 7
`define CTRL_DEMUX_BIT 8
`endif

// File: verilog/adc_ctrl_pkg.sv
// Types of the trim and control logic
package adc_ctrl_pkg;
  typedef enum logic [1:0] {
    TS_WAIT = 2'b00,
    TS_IDLE = 2'b01,
    TS_TRIM = 2'b10
  } trim_state_t;
  typedef enum logic [1:0] {
    SQ_IDLE = 2'b00,
    SQ_LOW = 2'b01,
    SQ_HIGH = 2'b10
  } seq_state_t;
  typedef logic [8:0] sample_t;
  typedef struct packed {
    trim_state_t st;
    logic strap_taken;
    logic suppress;
    logic [31:0] cnt;
    logic [15:0] low_cnt;
    logic [15:0] high_cnt;
    logic [15:0] trim_reg;
    logic [15:0] cfg_reg;
    logic [15:0] rdata;
    logic half;
    logic [13:0][8:0] pi;
    logic [13:0][8:0] pq;
    logic [7:0] ip;
    logic [7:0] qp;
    logic [7:0] id;
    logic [7:0] qd;
    logic rng;
    logic busy;
    logic upd;
    logic span_normal;
    logic swing_reduced;
    logic edge_rising;
  } dev_state_t;
  typedef struct packed {
    logic aw_got;
    logic [7:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] ctrl;
    logic mode_locked;
    seq_state_t seq;
    logic [15:0] seq_cnt;
    logic pending;
    logic [31:0] pu_cnt;
    logic pu_done;
    logic trim_pin;
    logic reg_write;
    logic [3:0] reg_addr;
    logic [15:0] reg_wdata;
    logic [23:0] capture;
    logic [7:0] discards;
  } host_state_t;
endpackage : adc_ctrl_pkg

// File: verilog/trim_link_if.sv
// Pins and parallel buses between the converter control logic and its controller
`timescale 1ns/10ps
interface trim_link_if;
  logic trim_request;
  logic power_down_pin;
  logic second_channel_sleep;
  logic input_span_select;
  logic output_swing_select;
  logic data_edge_select;
  logic power_up_trim_delay_select;
  logic extended_mode;
  logic demux_mode;
  logic reg_write;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic [7:0] i_bus_primary;
  logic [7:0] q_bus_primary;
  logic [7:0] i_bus_delayed;
  logic [7:0] q_bus_delayed;
  logic range_exceeded;
  logic trim_busy;
  logic bus_update;
  modport device (
    input trim_request, power_down_pin, second_channel_sleep, input_span_select,
    input output_swing_select, data_edge_select, power_up_trim_delay_select,
    input extended_mode, demux_mode, reg_write, reg_addr, reg_wdata,
    output reg_rdata, i_bus_primary, q_bus_primary, i_bus_delayed, q_bus_delayed,
    output range_exceeded, trim_busy, bus_update
  );
  modport host (
    output trim_request, power_down_pin, second_channel_sleep, input_span_select,
    output output_swing_select, data_edge_select, power_up_trim_delay_select,
    output extended_mode, demux_mode, reg_write, reg_addr, reg_wdata,
    input reg_rdata, i_bus_primary, q_bus_primary, i_bus_delayed, q_bus_delayed,
    input range_exceeded, trim_busy, bus_update
  );
endinterface : trim_link_if

// File: verilog/adc_trim_and_control_logic.sv
// Converter end: trim sequencing, control modes, output coding and pipeline
`timescale 1ns/10ps
`include "adc_ctrl_consts.svh"
module adc_trim_and_control_logic #(
  parameter logic [15:0] LOW_HOLD = `TRIM_LOW_HOLD_CYCLES,
  parameter logic [15:0] HIGH_HOLD = `TRIM_HIGH_HOLD_CYCLES,
  parameter logic [31:0] TRIM_CYCLES = `TRIM_RUN_CYCLES,
  parameter logic [31:0] WAIT_SHORT = `PU_WAIT_SHORT_CYCLES,
  parameter logic [31:0] WAIT_LONG = `PU_WAIT_LONG_CYCLES
) (
  // Clock and power-up reset
  input wire logic aclk,
  input wire logic aresetn,
  // Analog inputs as signed sample values
  input wire logic signed [15:0] i_analog,
  input wire logic signed [15:0] q_analog,
  // Effective settings
  output logic span_normal,
  output logic swing_reduced,
  output logic edge_rising,
  // Controller side
  trim_link_if.device link
);
  adc_ctrl_pkg::dev_state_t s;
  adc_ctrl_pkg::dev_state_t next_s;

  // ----------------------------------------
  // Conversion
  // ----------------------------------------
  function automatic adc_ctrl_pkg::sample_t convert(input logic signed [15:0] a,
                                                     input logic normal);
    logic signed [16:0] v;
    v = normal ? {a[15], a} : {a, 1'b0};
    if (v < -17'sd128)
      convert = {1'b1, 8'h00};
    else if (v > 17'sd127)
      convert = {1'b1, 8'hff};
    else
      convert = {1'b0, ~v[7], v[6:0]};
  endfunction : convert

  logic ext;
  logic span_now;
  logic delay_sel;
  logic pd;
  logic suppress_now;
  logic cmd;
  logic demux_tick;
  logic [31:0] wait_len;

  always_comb
  begin
    next_s = s;
    cmd = 1'b0;
    pd = link.power_down_pin;
    ext = link.extended_mode;
    // ----------------------------------------
    // Control mode
    // ----------------------------------------
    span_now = ext ? s.cfg_reg[`CFG_SPAN_BIT] : link.input_span_select;
    delay_sel = ext ? s.cfg_reg[`CFG_DELAY_BIT] : link.power_up_trim_delay_select;
    next_s.span_normal = span_now;
    next_s.swing_reduced = ext ? s.cfg_reg[`CFG_SWING_BIT] : link.output_swing_select;
    next_s.edge_rising = ext ? s.cfg_reg[`CFG_EDGE_BIT] : link.data_edge_select;
    wait_len = delay_sel ? WAIT_LONG : WAIT_SHORT;
    // Strap of the request pin, caught on the first edge after release
    suppress_now = s.strap_taken ? s.suppress : link.trim_request;
    if (!s.strap_taken)
    begin
      next_s.strap_taken = 1'b1;
      next_s.suppress = link.trim_request;
    end
    // ----------------------------------------
    // Pin command detector
    // ----------------------------------------
    if (!link.trim_request)
    begin
      next_s.high_cnt = 16'h0000;
      if (s.low_cnt != LOW_HOLD)
        next_s.low_cnt = s.low_cnt + 16'h0001;
    end
    else if (s.low_cnt == LOW_HOLD)
    begin
      if (s.high_cnt == HIGH_HOLD - 16'h0001)
      begin
        cmd = 1'b1;
        next_s.low_cnt = 16'h0000;
        next_s.high_cnt = 16'h0000;
      end
      else
        next_s.high_cnt = s.high_cnt + 16'h0001;
    end
    else
      next_s.low_cnt = 16'h0000;
    // ----------------------------------------
    // Register port
    // ----------------------------------------
    if (link.reg_write && link.reg_addr == `DEV_TRIM_REG)
    begin
      next_s.trim_reg = link.reg_wdata;
      next_s.trim_reg[`TRIM_START_BIT] = 1'b0;
      if (link.reg_wdata[`TRIM_START_BIT])
        cmd = 1'b1;
    end
    if (link.reg_write && link.reg_addr == `DEV_CONFIG_REG)
      next_s.cfg_reg = link.reg_wdata;
    case (link.reg_addr)
      `DEV_TRIM_REG:
      begin
        next_s.rdata = s.trim_reg;
        next_s.rdata[`TRIM_START_BIT] = s.busy;
      end
      `DEV_CONFIG_REG: next_s.rdata = s.cfg_reg;
      default: next_s.rdata = 16'h0000;
    endcase
    // ----------------------------------------
    // Trim sequencer
    // ----------------------------------------
    case (s.st)
      adc_ctrl_pkg::TS_WAIT:
      begin
        if (cmd && !pd)
        begin
          next_s.st = adc_ctrl_pkg::TS_TRIM;
          next_s.cnt = 32'h0000_0000;
        end
        else if (pd)
          next_s.cnt = s.cnt;
        else if (s.cnt >= wait_len - 32'h0000_0001)
        begin
          next_s.cnt = 32'h0000_0000;
          next_s.st = suppress_now ? adc_ctrl_pkg::TS_IDLE : adc_ctrl_pkg::TS_TRIM;
        end
        else
          next_s.cnt = s.cnt + 32'h0000_0001;
      end
      adc_ctrl_pkg::TS_IDLE:
      begin
        if (cmd && !pd)
        begin
          next_s.st = adc_ctrl_pkg::TS_TRIM;
          next_s.cnt = 32'h0000_0000;
        end
      end
      adc_ctrl_pkg::TS_TRIM:
      begin
        if (pd || s.cnt == TRIM_CYCLES - 32'h0000_0001)
        begin
          next_s.st = adc_ctrl_pkg::TS_IDLE;
          next_s.cnt = 32'h0000_0000;
        end
        else
          next_s.cnt = s.cnt + 32'h0000_0001;
      end
      default:
      begin
        next_s.st = adc_ctrl_pkg::TS_WAIT;
        next_s.cnt = 32'h0000_0000;
      end
    endcase
    next_s.busy = (next_s.st == adc_ctrl_pkg::TS_TRIM);
    // ----------------------------------------
    // Pipeline and output buses
    // ----------------------------------------
    next_s.pi = {s.pi[`PIPE_DEPTH-2:0], convert(i_analog, span_now)};
    next_s.pq = {s.pq[`PIPE_DEPTH-2:0], convert(q_analog, span_now)};
    next_s.half = ~s.half;
    demux_tick = link.demux_mode ? s.half : 1'b1;
    next_s.upd = demux_tick;
    if (demux_tick)
    begin
      next_s.ip = s.pi[`PIPE_PRIMARY][7:0];
      next_s.qp = s.pq[`PIPE_PRIMARY][7:0];
      next_s.id = link.demux_mode ? s.pi[`PIPE_DELAYED][7:0] : 8'h00;
      next_s.qd = link.demux_mode ? s.pq[`PIPE_DELAYED][7:0] : 8'h00;
      next_s.rng = s.pi[`PIPE_PRIMARY][8] | (link.demux_mode & s.pi[`PIPE_DELAYED][8])
        | (~link.second_channel_sleep & (s.pq[`PIPE_PRIMARY][8]
        | (link.demux_mode & s.pq[`PIPE_DELAYED][8])));
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s <= '0;
      s.st <= adc_ctrl_pkg::TS_WAIT;
      s.trim_reg <= `DEV_REG_RESET;
      s.cfg_reg <= `DEV_REG_RESET;
    end
    else
      s <= next_s;
  end

  assign span_normal = s.span_normal;
  assign swing_reduced = s.swing_reduced;
  assign edge_rising = s.edge_rising;
  assign link.reg_rdata = s.rdata;
  assign link.i_bus_primary = s.ip;
  assign link.q_bus_primary = s.qp;
  assign link.i_bus_delayed = s.id;
  assign link.q_bus_delayed = s.qd;
  assign link.range_exceeded = s.rng;
  assign link.trim_busy = s.busy;
  assign link.bus_update = s.upd;
endmodule : adc_trim_and_control_logic

// File: verilog/adc_trim_controller.sv
// Controller end: AXI4-Lite registers, trim request sequencing and data capture
`timescale 1ns/10ps
`include "adc_ctrl_consts.svh"
module adc_trim_controller #(
  parameter logic [15:0] LOW_HOLD = `TRIM_LOW_HOLD_CYCLES,
  parameter logic [15:0] HIGH_HOLD = `TRIM_HIGH_HOLD_CYCLES,
  parameter logic [31:0] POST_POWER_CYCLES = 32'(`POST_POWER_TRIM_S * `CLK_HZ)
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Converter side
  trim_link_if.host link
);
  adc_ctrl_pkg::host_state_t s;
  adc_ctrl_pkg::host_state_t next_s;
  logic [31:0] merged;
  logic [31:0] rd;
  logic go;

  always_comb
  begin
    next_s = s;
    go = 1'b0;
    merged = s.ctrl;
    next_s.reg_write = 1'b0;
    // ----------------------------------------
    // AXI4-Lite write
    // ----------------------------------------
    if (s_axi_awvalid && s.awready)
    begin
      next_s.aw_got = 1'b1;
      next_s.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s.wready)
    begin
      next_s.w_got = 1'b1;
      next_s.wdata = s_axi_wdata;
      next_s.wstrb = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready)
      next_s.bvalid = 1'b0;
    if (s.aw_got && s.w_got && !s.bvalid)
    begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = 2'b00;
      for (int b = 0; b < 4; b++)
        if (s.wstrb[b])
          merged[b*8 +: 8] = s.wdata[b*8 +: 8];
      case (s.awaddr)
        `HOST_CTRL:
        begin
          next_s.ctrl = merged;
          next_s.ctrl[`CTRL_TRIM_BIT] = 1'b0;
          next_s.mode_locked = 1'b1;
          if (s.mode_locked)
            next_s.ctrl[`CTRL_EXT_BIT] = s.ctrl[`CTRL_EXT_BIT];
          go = merged[`CTRL_TRIM_BIT]
            | (merged[`CTRL_SPAN_BIT] != s.ctrl[`CTRL_SPAN_BIT]);
        end
        `HOST_DEVREG:
        begin
          next_s.reg_write = 1'b1;
          next_s.reg_addr = s.wdata[19:16];
          next_s.reg_wdata = s.wdata[15:0];
        end
        `HOST_STATUS, `HOST_CAPTURE: next_s.bresp = 2'b00;
        default: next_s.bresp = 2'b10;
      endcase
    end
    next_s.awready = ~next_s.aw_got & ~next_s.bvalid;
    next_s.wready = ~next_s.w_got & ~next_s.bvalid;
    // ----------------------------------------
    // AXI4-Lite read
    // ----------------------------------------
    case (s_axi_araddr)
      `HOST_CTRL: rd = s.ctrl;
      `HOST_STATUS: rd = {16'h0000, s.discards, 5'h00, s.pu_done,
                          (s.seq != adc_ctrl_pkg::SQ_IDLE), link.trim_busy};
      `HOST_CAPTURE: rd = {8'h00, s.capture};
      `HOST_DEVREG: rd = {16'h0000, link.reg_rdata};
      default: rd = 32'h0000_0000;
    endcase
    if (s.rvalid && s_axi_rready)
      next_s.rvalid = 1'b0;
    if (s_axi_arvalid && s.arready)
    begin
      next_s.rvalid = 1'b1;
      next_s.rdata = rd;
      next_s.rresp = (s_axi_araddr[7:4] == 4'h0 && s_axi_araddr[1:0] == 2'b00)
        ? 2'b00 : 2'b10;
    end
    next_s.arready = ~next_s.rvalid;
    // ----------------------------------------
    // Trim request sequencer
    // ----------------------------------------
    if (!s.pu_done)
    begin
      if (s.pu_cnt == POST_POWER_CYCLES - 32'h0000_0001)
      begin
        next_s.pu_done = 1'b1;
        go = 1'b1;
      end
      else
        next_s.pu_cnt = s.pu_cnt + 32'h0000_0001;
    end
    if (go)
      next_s.pending = 1'b1;
    case (s.seq)
      adc_ctrl_pkg::SQ_IDLE:
      begin
        next_s.trim_pin = 1'b1;
        if (s.pending)
        begin
          next_s.pending = go;
          next_s.seq = adc_ctrl_pkg::SQ_LOW;
          next_s.seq_cnt = 16'h0000;
          next_s.trim_pin = 1'b0;
        end
      end
      adc_ctrl_pkg::SQ_LOW:
      begin
        if (s.seq_cnt == LOW_HOLD - 16'h0001)
        begin
          next_s.seq = adc_ctrl_pkg::SQ_HIGH;
          next_s.seq_cnt = 16'h0000;
          next_s.trim_pin = 1'b1;
        end
        else
          next_s.seq_cnt = s.seq_cnt + 16'h0001;
      end
      adc_ctrl_pkg::SQ_HIGH:
      begin
        if (s.seq_cnt == HIGH_HOLD - 16'h0001)
          next_s.seq = adc_ctrl_pkg::SQ_IDLE;
        else
          next_s.seq_cnt = s.seq_cnt + 16'h0001;
      end
      default: next_s.seq = adc_ctrl_pkg::SQ_IDLE;
    endcase
    // ----------------------------------------
    // Capture
    // ----------------------------------------
    if (link.bus_update)
    begin
      if (link.trim_busy)
        next_s.discards = s.discards + 8'h01;
      else
        next_s.capture = {7'h00, link.range_exceeded, link.q_bus_primary,
                          link.i_bus_primary};
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s <= '0;
      s.ctrl <= `HOST_CTRL_RESET;
      s.trim_pin <= 1'b1;
      s.seq <= adc_ctrl_pkg::SQ_IDLE;
    end
    else
      s <= next_s;
  end

  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign link.trim_request = s.trim_pin;
  assign link.power_down_pin = s.ctrl[`CTRL_PD_BIT];
  assign link.second_channel_sleep = s.ctrl[`CTRL_SLEEP_BIT];
  assign link.input_span_select = s.ctrl[`CTRL_SPAN_BIT];
  assign link.output_swing_select = s.ctrl[`CTRL_SWING_BIT];
  assign link.data_edge_select = s.ctrl[`CTRL_EDGE_BIT];
  assign link.power_up_trim_delay_select = s.ctrl[`CTRL_DELAY_BIT];
  assign link.extended_mode = s.ctrl[`CTRL_EXT_BIT];
  assign link.demux_mode = s.ctrl[`CTRL_DEMUX_BIT];
  assign link.reg_write = s.reg_write;
  assign link.reg_addr = s.reg_addr;
  assign link.reg_wdata = s.reg_wdata;
endmodule : adc_trim_controller

// File: testbench/trim_link_monitor.sv
// Checker of the trim link between converter and controller
`timescale 1ns/10ps
module trim_link_monitor #(
  parameter int LOW_HOLD = 16,
  parameter int HIGH_HOLD = 16,
  parameter int TRIM_CYCLES = 30
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Link signals
  input wire logic trim_request,
  input wire logic power_down_pin,
  input wire logic demux_mode,
  input wire logic reg_write,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic trim_busy,
  input wire logic bus_update
);
  logic [7:0] up, lo, hi, bz;
  logic qual;
  logic [1:0] dm;
  wire ok = up > 8'h03;
  wire dm1 = ok && demux_mode && (dm == 2'b11);
  wire dm0 = ok && !demux_mode && (dm == 2'b00);
  // ----------
  // Run counters
  // ----------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      up <= 8'h00;
      lo <= 8'h00;
      hi <= 8'h00;
      bz <= 8'h00;
      qual <= 1'b0;
      dm <= 2'b00;
    end
    else
    begin
      up <= up + {7'h00, up != 8'hff};
      lo <= trim_request ? 8'h00 : lo + {7'h00, lo != 8'hff};
      hi <= trim_request ? hi + {7'h00, hi != 8'hff} : 8'h00;
      qual <= (trim_request && hi == 8'h00) ? (lo >= 8'(LOW_HOLD)) : qual;
      bz <= trim_busy ? bz + 8'h01 : 8'h00;
      dm <= {dm[0], demux_mode};
    end
  end
  // ----------
  // Properties
  // ----------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_low_hold_len: assert property ($rose(trim_request) |-> lo == 8'(LOW_HOLD))
    else $error("trim request low time wrong");
  a_pin_cmd_trim: assert property (trim_request && hi == 8'(HIGH_HOLD - 1) && qual
    && !power_down_pin && !trim_busy |-> ##[1:2] trim_busy)
    else $error("pin command started no trim");
  a_reg_cmd_trim: assert property (reg_write && reg_addr == 4'h0 && reg_wdata[15]
    && !power_down_pin && !trim_busy |-> ##[1:2] trim_busy)
    else $error("register command started no trim");
  a_trim_run_len: assert property ($fell(trim_busy) && !$past(power_down_pin)
    |-> bz == 8'(TRIM_CYCLES))
    else $error("trim length wrong");
  a_pd_no_trim: assert property (power_down_pin && $past(power_down_pin) |-> !trim_busy)
    else $error("trim runs in power down");
  a_full_rate_upd: assert property (dm0 |-> bus_update)
    else $error("non-demux bus missed an update");
  a_half_rate_upd: assert property (dm1 && bus_update |=> !bus_update)
    else $error("demux bus updated twice in a row");
  a_half_rate_gap: assert property (dm1 && !bus_update |=> bus_update)
    else $error("demux bus skipped an update");
  c_trim: cover property ($rose(trim_busy));
  c_abort: cover property ($fell(trim_busy) && $past(power_down_pin));
  c_demux: cover property (dm1 && bus_update);
endmodule : trim_link_monitor

// File: testbench/adc_trim_and_control_logic_test.sv
// Bench joining converter end and controller end
`timescale 1ns/10ps
`include "adc_ctrl_consts.svh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; \
  $display("ERROR %s exp %0h got %0h", n, e, g); end end
module adc_trim_and_control_logic_test;
  localparam logic [31:0] TRIM = 32'h0000_001e;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic signed [15:0] i_analog = 16'sh0000, q_analog = 16'sh0000;
  logic span_normal, swing_reduced, edge_rising;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hf;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, d;
  logic [1:0] r;
  int failures = 0;
  int total_checks = 0;
  always #2.5 aclk = ~aclk;
  // ----------
  // Design
  // ----------
  trim_link_if trim_link_if_i ();
  adc_trim_and_control_logic #(.TRIM_CYCLES(TRIM), .WAIT_SHORT(32'h0000_0014),
    .WAIT_LONG(32'h0000_0028)) adc_trim_and_control_logic_i (.aclk(aclk), .aresetn(aresetn),
    .i_analog(i_analog), .q_analog(q_analog), .span_normal(span_normal),
    .swing_reduced(swing_reduced), .edge_rising(edge_rising), .link(trim_link_if_i));
  adc_trim_controller #(.POST_POWER_CYCLES(32'h0000_07d0)) adc_trim_controller_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .link(trim_link_if_i));
  trim_link_monitor #(.TRIM_CYCLES(TRIM)) trim_link_monitor_i (.aclk(aclk), .aresetn(aresetn),
    .trim_request(trim_link_if_i.trim_request), .power_down_pin(trim_link_if_i.power_down_pin),
    .demux_mode(trim_link_if_i.demux_mode), .reg_write(trim_link_if_i.reg_write),
    .reg_addr(trim_link_if_i.reg_addr), .reg_wdata(trim_link_if_i.reg_wdata),
    .trim_busy(trim_link_if_i.trim_busy), .bus_update(trim_link_if_i.bus_update));
  // ----------
  // Bus tasks
  // ----------
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (awvalid || wvalid);
    while (bvalid !== 1'b1) @(posedge aclk);
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
  // ----------
  // Scenarios
  // ----------
  task automatic t_regs();
    rd(`HOST_CTRL);
    `CHK("ctrl reset", `HOST_CTRL_RESET, d)
    rd(8'h10);
    `CHK("unmapped resp", 2'b10, r)
    // Look inside the window a power-up trim would occupy
    cyc(20);
    rd(`HOST_STATUS);
    `CHK("strap busy", 1'b0, d[0])
  endtask : t_regs
  task automatic t_trims();
    int n;
    wr(`HOST_DEVREG, 32'h0000_8000);
    rd(`HOST_STATUS);
    `CHK("reg trim busy", 1'b1, d[0])
    cyc(40);
    rd(`HOST_STATUS);
    `CHK("reg trim done", 1'b0, d[0])
    wr(`HOST_CTRL, 32'h0000_0009);
    n = 0;
    while (trim_link_if_i.trim_busy !== 1'b1 && n < 60)
    begin
      @(posedge aclk);
      n++;
    end
    `CHK("pin trim", 1'b1, trim_link_if_i.trim_busy)
    cyc(40);
    // Power down aborts a running trim, then refuses a new one
    wr(`HOST_DEVREG, 32'h0000_8000);
    wr(`HOST_CTRL, 32'h0000_000a);
    wr(`HOST_DEVREG, 32'h0000_8000);
    cyc(4);
    `CHK("pd trim", 1'b0, trim_link_if_i.trim_busy)
    wr(`HOST_CTRL, 32'h0000_0008);
  endtask : t_trims
  task automatic t_codes();
    int vl[7] = '{1, 127, -128, 200, -5, -300, 0};
    logic [7:0] cd[7] = '{8'h81, 8'hff, 8'h00, 8'hff, 8'h7b, 8'h00, 8'h80};
    logic rg[7] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    int n;
    foreach (vl[k])
    begin
      i_analog <= 16'(vl[k]);
      n = 0;
      do
      begin
        @(posedge aclk);
        n++;
      end while (trim_link_if_i.i_bus_primary !== cd[k] && n < 40);
      // Assign edge, sample edge, then 13 clocks
      `CHK("latency", 15, n)
      `CHK("range", rg[k], trim_link_if_i.range_exceeded)
    end
  endtask : t_codes
  task automatic t_flags();
    i_analog <= 16'sh0000;
    q_analog <= 16'sh012c;
    cyc(20);
    `CHK("q range", 1'b1, trim_link_if_i.range_exceeded)
    wr(`HOST_CTRL, 32'h0000_000c);
    cyc(20);
    `CHK("sleep range", 1'b0, trim_link_if_i.range_exceeded)
    q_analog <= 16'sh0000;
    wr(`HOST_CTRL, 32'h0000_0000);
    i_analog <= 16'sh0028;
    cyc(20);
    `CHK("span out", 1'b0, span_normal)
    `CHK("reduced code", 8'hd0, trim_link_if_i.i_bus_primary)
    i_analog <= 16'sh0040;
    cyc(20);
    `CHK("reduced range", 1'b1, trim_link_if_i.range_exceeded)
    wr(`HOST_CTRL, 32'h0000_0008);
    cyc(100);
  endtask : t_flags
  task automatic t_demux();
    int c;
    c = 0;
    i_analog <= 16'sh000a;
    q_analog <= -16'sh000a;
    wr(`HOST_CTRL, 32'h0000_0108);
    cyc(30);
    `CHK("i delayed", 8'h8a, trim_link_if_i.i_bus_delayed)
    `CHK("q delayed", 8'h76, trim_link_if_i.q_bus_delayed)
    rd(`HOST_CAPTURE);
    `CHK("capture", 32'h0000_768a, d)
    repeat (20)
    begin
      @(posedge aclk);
      c += int'(trim_link_if_i.bus_update === 1'b1);
    end
    `CHK("demux rate", 10, c)
    wr(`HOST_CTRL, 32'h0000_0008);
  endtask : t_demux
  task automatic t_ext();
    aresetn <= 1'b0;
    cyc(4);
    aresetn <= 1'b1;
    wr(`HOST_CTRL, 32'h0000_0098);
    cyc(3);
    `CHK("ext span", 1'b0, span_normal)
    `CHK("ext swing", 1'b0, swing_reduced)
    wr(`HOST_DEVREG, 32'h0001_0007);
    cyc(3);
    `CHK("reg span", 1'b1, span_normal)
    `CHK("reg swing", 1'b1, swing_reduced)
    `CHK("reg edge", 1'b1, edge_rising)
    rd(`HOST_DEVREG);
    `CHK("dev cfg", 32'h0000_0007, d)
    cyc(2100);
    rd(`HOST_STATUS);
    `CHK("post trim", 1'b1, d[2])
  endtask : t_ext
  task automatic finish_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_trims();
    t_codes();
    t_flags();
    t_demux();
    t_ext();
    finish_test();
  end
  initial
  begin
    #50000;
    failures++;
    finish_test();
  end
endmodule : adc_trim_and_control_logic_test
